//--- logic/gpp_params.svh
// constants for the three-port pin block: offsets, field positions, resets
`ifndef GPP_PARAMS_SVH
`define GPP_PARAMS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define GPP_IDX_PORT_B 10'h09A
`define GPP_IDX_PORT_C 10'h09E
`define GPP_IDX_PORT_D 10'h0A2
`define GPP_IDX_PWRDN 10'h0DB
`define GPP_REGS_PER_PORT 10'h004

// ==========================================================
// register select within one port
`define GPP_SEL_VALUE 2'h0
`define GPP_SEL_DIR 2'h1
`define GPP_SEL_ALT1 2'h2
`define GPP_SEL_ALT2 2'h3

// ==========================================================
// power-down bit positions for ports b, c, d
`define GPP_PD_BIT_B 5
`define GPP_PD_BIT_C 6
`define GPP_PD_BIT_D 7
`define GPP_PD_MASK 8'hE0

// ==========================================================
// reset values
`define GPP_VALUE_RST 8'h00
`define GPP_DIR_RST 8'hFF
`define GPP_ALT_RST 8'h00
`define GPP_PWRDN_RST 8'h00
`define GPP_ZERO8 8'h00
`define GPP_ONES8 8'hFF
`define GPP_ZERO32 32'h0000_0000

// ==========================================================
// vectors: first pin vector and spacing between pins
`define GPP_VEC_BASE 8'h30
`define GPP_VEC_STEP 8'h02
`define GPP_NPINS 24
`define GPP_NPORTS 3

`endif

//--- logic/gpp_pkg.sv
// types shared by the pin block modules
package gpp_pkg;

  // ==========================================================
  // pin operating modes
  typedef enum logic [3:0] {
    GPP_M_OUT,
    GPP_M_IN,
    GPP_M_ODRAIN,
    GPP_M_OSRC,
    GPP_M_RSVD,
    GPP_M_DUAL,
    GPP_M_ALT,
    GPP_M_LEVEL,
    GPP_M_SINGLE
  } gpp_mode_t;

  // ==========================================================
  // the four control registers of one port
  typedef struct packed {
    logic [7:0] value;
    logic [7:0] dir;
    logic [7:0] alt1;
    logic [7:0] alt2;
  } gpp_ctl_t;

  // register select decoded from an apb index
  typedef struct packed {
    logic hit;
    logic pwr;
    logic [1:0] port;
    logic [1:0] sel;
  } gpp_sel_t;

  // state of one port
  typedef struct packed {
    logic [7:0] smp;
    logic [7:0] prv;
    logic [7:0] pend;
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] alt_in;
    logic [7:0] irq;
  } gpp_port_st_t;

  // state of the top: registers and bus answer
  typedef struct packed {
    gpp_ctl_t [2:0] ctl;
    logic [7:0] pwrdn;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [7:0] vec;
    logic irq_any;
  } gpp_top_st_t;

  // mode from alt2, alt1, direction bits of one pin
  function automatic gpp_mode_t gpp_decode(input logic a2, input logic a1,
                                           input logic d);
    case ({a2, a1, d})
      3'h0: gpp_decode = GPP_M_OUT;
      3'h1: gpp_decode = GPP_M_IN;
      3'h2: gpp_decode = GPP_M_ODRAIN;
      3'h3: gpp_decode = GPP_M_OSRC;
      3'h4: gpp_decode = GPP_M_DUAL;
      3'h5: gpp_decode = GPP_M_ALT;
      3'h6: gpp_decode = GPP_M_LEVEL;
      3'h7: gpp_decode = GPP_M_SINGLE;
      default: gpp_decode = GPP_M_RSVD;
    endcase
  endfunction

endpackage

//--- logic/gpp_port.sv
// one eight-pin port: sampling, drivers and pin requests
`timescale 1ns/1ns
`include "gpp_params.svh"

module gpp_port (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // port clock running, write-one clear pulses, control
  input wire logic en,
  input wire logic [7:0] clr,
  input gpp_pkg::gpp_ctl_t ctl,
  // pins and alternate function
  input wire logic [7:0] pin_in,
  input wire logic [7:0] alt_out,
  input wire logic [7:0] alt_oe,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] alt_in,
  output logic [7:0] smp,
  output logic [7:0] irq
);
  import gpp_pkg::*;

  gpp_port_st_t st;
  gpp_port_st_t next_st;

  // per-pin mode decode, drivers and request logic
  always_comb begin
    gpp_mode_t m;
    logic rise;
    logic fall;
    m = GPP_M_IN;
    rise = 1'b0;
    fall = 1'b0;
    next_st = st;
    if (en) begin
      next_st.smp = pin_in;
      next_st.prv = st.smp;
      next_st.alt_in = st.smp;
      for (int i = 0; i < 8; i++) begin
        m = gpp_decode(ctl.alt2[i], ctl.alt1[i], ctl.dir[i]);
        rise = st.smp[i] & ~st.prv[i];
        fall = ~st.smp[i] & st.prv[i];
        next_st.out[i] = 1'b0;
        next_st.oe[i] = 1'b0;
        next_st.pend[i] = 1'b0;
        next_st.irq[i] = 1'b0;
        case (m)
          GPP_M_OUT: begin
            next_st.out[i] = ctl.value[i];
            next_st.oe[i] = 1'b1;
          end
          GPP_M_IN: begin
            next_st.oe[i] = 1'b0;
          end
          GPP_M_ODRAIN: begin
            next_st.oe[i] = ~ctl.value[i];
          end
          GPP_M_OSRC: begin
            next_st.out[i] = 1'b1;
            next_st.oe[i] = ctl.value[i];
          end
          GPP_M_DUAL: begin
            // set wins over a write-one clear in the same cycle
            next_st.pend[i] = rise | fall | (st.pend[i] & ~clr[i]);
            next_st.irq[i] = next_st.pend[i];
          end
          GPP_M_ALT: begin
            next_st.out[i] = alt_out[i];
            next_st.oe[i] = alt_oe[i];
          end
          GPP_M_LEVEL: begin
            next_st.irq[i] = (st.smp[i] == ctl.value[i]) &
                             (st.prv[i] == ctl.value[i]);
          end
          GPP_M_SINGLE: begin
            next_st.pend[i] = (ctl.value[i] ? rise : fall) |
                              (st.pend[i] & ~clr[i]);
            next_st.irq[i] = next_st.pend[i];
          end
          default: begin
            next_st.oe[i] = 1'b0;
          end
        endcase
      end
    end
  end

  // state register; a gated port holds its state
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin_out = st.out;
  assign pin_oe = st.oe;
  assign alt_in = st.alt_in;
  assign smp = st.smp;
  assign irq = st.irq;

endmodule

//--- logic/gpp_prio.sv
// fixed-priority encoder: lowest pin index wins
`timescale 1ns/1ns
`include "gpp_params.svh"

module gpp_prio (
  // requests, bit 0 highest priority
  input wire logic [23:0] req,
  // winner
  output logic valid,
  output logic [7:0] vec
);
  // scan from the lowest-priority end so the lowest index lands last
  always_comb begin
    valid = 1'b0;
    vec = `GPP_ZERO8;
    for (int i = `GPP_NPINS - 1; i >= 0; i--) begin
      if (req[i]) begin
        valid = 1'b1;
        vec = `GPP_VEC_BASE + 8'(i) * `GPP_VEC_STEP;
      end
    end
  end

endmodule

//--- logic/gpp_top.sv
// three-port pin block with apb registers and vectored requests
`timescale 1ns/1ns
`include "gpp_params.svh"

module gpp_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // pins, b in bits 7:0, c in 15:8, d in 23:16
  input wire logic [23:0] pin_in,
  output logic [23:0] pin_out,
  output logic [23:0] pin_oe,
  // alternate functions
  input wire logic [23:0] alt_out,
  input wire logic [23:0] alt_oe,
  output logic [23:0] alt_in,
  // requests toward the interrupt controller
  output logic [23:0] irq_req,
  output logic irq_any,
  output logic [7:0] irq_vector
);
  import gpp_pkg::*;

  // ==========================================================
  // address decode
  function automatic gpp_sel_t gpp_addr_dec(input logic [9:0] idx);
    gpp_sel_t s;
    s = '0;
    if (idx == `GPP_IDX_PWRDN) begin
      s.hit = 1'b1;
      s.pwr = 1'b1;
    end else if (idx >= `GPP_IDX_PORT_B &&
                 idx < `GPP_IDX_PORT_B + `GPP_REGS_PER_PORT) begin
      s.hit = 1'b1;
      s.port = 2'h0;
      s.sel = 2'(idx - `GPP_IDX_PORT_B);
    end else if (idx >= `GPP_IDX_PORT_C &&
                 idx < `GPP_IDX_PORT_C + `GPP_REGS_PER_PORT) begin
      s.hit = 1'b1;
      s.port = 2'h1;
      s.sel = 2'(idx - `GPP_IDX_PORT_C);
    end else if (idx >= `GPP_IDX_PORT_D &&
                 idx < `GPP_IDX_PORT_D + `GPP_REGS_PER_PORT) begin
      s.hit = 1'b1;
      s.port = 2'h2;
      s.sel = 2'(idx - `GPP_IDX_PORT_D);
    end
    gpp_addr_dec = s;
  endfunction

  // ==========================================================
  // state and port wiring
  gpp_top_st_t st;
  gpp_top_st_t next_st;
  logic [2:0] port_en;
  logic [2:0][7:0] clr;
  logic [23:0] smp;
  logic [23:0] irq_w;
  logic prio_valid;
  logic [7:0] prio_vec;

  // port clocks run unless their power-down bit is set
  assign port_en[0] = ~st.pwrdn[`GPP_PD_BIT_B];
  assign port_en[1] = ~st.pwrdn[`GPP_PD_BIT_C];
  assign port_en[2] = ~st.pwrdn[`GPP_PD_BIT_D];

  // three identical ports
  generate
    for (genvar p = 0; p < `GPP_NPORTS; p++) begin : g_port
      gpp_port u_port (
        .clk(clk),
        .rst(rst),
        .en(port_en[p]),
        .clr(clr[p]),
        .ctl(st.ctl[p]),
        .pin_in(pin_in[8*p +: 8]),
        .alt_out(alt_out[8*p +: 8]),
        .alt_oe(alt_oe[8*p +: 8]),
        .pin_out(pin_out[8*p +: 8]),
        .pin_oe(pin_oe[8*p +: 8]),
        .alt_in(alt_in[8*p +: 8]),
        .smp(smp[8*p +: 8]),
        .irq(irq_w[8*p +: 8])
      );
    end
  endgenerate

  // pick the highest-priority pending pin
  gpp_prio u_prio (
    .req(irq_w),
    .valid(prio_valid),
    .vec(prio_vec)
  );

  // ==========================================================
  // bus answer, register writes and clear pulses
  always_comb begin
    gpp_sel_t s;
    logic ok;
    logic wr;
    logic [7:0] rd;
    s = gpp_addr_dec(paddr[11:2]);
    ok = 1'b0;
    wr = 1'b0;
    rd = `GPP_ZERO8;
    next_st = st;
    clr = '0;
    // a port register is usable only while that port's clock runs
    ok = s.hit & (s.pwr | port_en[s.port]);
    wr = psel & penable & st.pready & pwrite & ok;
    case (s.sel)
      `GPP_SEL_VALUE: rd = smp[8*s.port +: 8];
      `GPP_SEL_DIR: rd = st.ctl[s.port].dir;
      `GPP_SEL_ALT1: rd = st.ctl[s.port].alt1;
      `GPP_SEL_ALT2: rd = st.ctl[s.port].alt2;
      default: rd = `GPP_ZERO8;
    endcase
    if (s.pwr) begin
      rd = st.pwrdn;
    end
    // answer in the first access cycle
    next_st.pready = psel & ~penable;
    if (psel & ~penable) begin
      next_st.pslverr = ~ok;
      next_st.prdata = (ok & ~pwrite) ? {24'h00_0000, rd} : `GPP_ZERO32;
    end else if (psel & penable & st.pready) begin
      next_st.pslverr = 1'b0;
      next_st.prdata = `GPP_ZERO32;
    end
    // writes take effect at the edge that completes the access
    if (wr) begin
      if (s.pwr) begin
        next_st.pwrdn = pwdata[7:0] & `GPP_PD_MASK;
      end else begin
        case (s.sel)
          `GPP_SEL_VALUE: begin
            next_st.ctl[s.port].value = pwdata[7:0];
            clr[s.port] = pwdata[7:0];
          end
          `GPP_SEL_DIR: next_st.ctl[s.port].dir = pwdata[7:0];
          `GPP_SEL_ALT1: next_st.ctl[s.port].alt1 = pwdata[7:0];
          `GPP_SEL_ALT2: next_st.ctl[s.port].alt2 = pwdata[7:0];
          default: next_st.pslverr = 1'b0;
        endcase
      end
    end
    // vector of the lowest pending pin
    next_st.vec = prio_valid ? prio_vec : `GPP_ZERO8;
    next_st.irq_any = prio_valid;
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int p = 0; p < `GPP_NPORTS; p++) begin
        st.ctl[p].value <= `GPP_VALUE_RST;
        st.ctl[p].dir <= `GPP_DIR_RST;
        st.ctl[p].alt1 <= `GPP_ALT_RST;
        st.ctl[p].alt2 <= `GPP_ALT_RST;
      end
      st.pwrdn <= `GPP_PWRDN_RST;
      st.pready <= 1'b0;
      st.pslverr <= 1'b0;
      st.prdata <= `GPP_ZERO32;
      st.vec <= `GPP_ZERO8;
      st.irq_any <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign prdata = st.prdata;
  assign irq_req = irq_w;
  assign irq_any = st.irq_any;
  assign irq_vector = st.vec;

endmodule

//--- tb/gpp_pins_model.sv
// pin wires and the external devices hanging on them
`timescale 1ns/1ns
module gpp_pins_model (
  // clock
  input wire logic clk,
  // block side drivers
  input wire logic [23:0] drv_out,
  input wire logic [23:0] drv_oe,
  // external device drivers
  input wire logic [23:0] ext_en,
  input wire logic [23:0] ext_val,
  // resolved level
  output logic [23:0] lvl
);
  logic [23:0] last = 24'h00_0000;
  // no pull on the wire: a floating pin shows the inverse of its last level
  always_comb begin
    lvl = (drv_oe & drv_out) | (~drv_oe & ext_en & ext_val)
      | (~drv_oe & ~ext_en & ~last);
  end
  // remember the level for the floating case
  always_ff @(posedge clk) begin
    last <= lvl;
  end
endmodule

//--- tb/gpp_props.sv
// assertion checker for the three-port pin block
`timescale 1ns/1ns
module gpp_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  // pins and requests
  input wire logic [23:0] pin_in,
  input wire logic [23:0] alt_in,
  input wire logic [23:0] irq_req,
  input wire logic irq_any,
  input wire logic [7:0] irq_vector
);
  logic [7:0] pd;
  // shadow of the power-down register, frozen ports stop sampling
  always_ff @(posedge clk) begin
    if (rst) begin
      pd <= 8'h00;
    end else if (psel && penable && pready && pwrite && paddr == 12'h36C) begin
      pd <= pwdata[7:0];
    end
  end
  // ==========================================================
  // properties
  a_reset_quiet: assert property (@(posedge clk) rst |=>
    irq_req == 24'h00_0000 && !pready && irq_vector == 8'h00)
    else $error("outputs not quiet after reset");
  a_ready_after_setup: assert property (@(posedge clk) disable iff (rst)
    psel && !penable |=> pready) else $error("no answer after setup");
  a_ready_once: assert property (@(posedge clk) disable iff (rst)
    pready |=> !pready) else $error("ready held two cycles");
  a_err_with_ready: assert property (@(posedge clk) disable iff (rst)
    pslverr |-> pready) else $error("error without ready");
  a_read_upper_zero: assert property (@(posedge clk) disable iff (rst)
    pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_alt_in_delay: assert property (@(posedge clk) disable iff (rst)
    pd == 8'h00 && $past(pd, 2) == 8'h00 && !$past(rst, 2) |->
    alt_in == $past(pin_in, 2)) else $error("alternate input not delayed");
  a_irq_any_follow: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> irq_any == (|$past(irq_req)))
    else $error("summary request mismatch");
  a_vector_map: assert property (@(posedge clk) disable iff (rst)
    $past(irq_req[8]) && $past(irq_req[7:0]) == 8'h00 |->
    irq_vector == 8'h40) else $error("wrong vector for port c pin 0");
  // main scenarios
  c_edge: cover property (@(posedge clk) $rose(irq_req[8]));
  c_err: cover property (@(posedge clk) pslverr);
  c_level: cover property (@(posedge clk) $rose(irq_req[16]));
endmodule

bind gpp_top gpp_props chk_u (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .prdata(prdata), .pin_in(pin_in),
  .alt_in(alt_in), .irq_req(irq_req), .irq_any(irq_any),
  .irq_vector(irq_vector));

//--- tb/testbench.sv
// self-checking bench for the three-port pin block
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, irq_any;
  logic [23:0] pin_in, pin_out, pin_oe, alt_in, irq_req;
  logic [23:0] ext_en = 24'hFF_FF00;
  logic [23:0] ext_val = 24'hFF_0000;
  logic [23:0] alt_out = 24'h00_003C;
  logic [23:0] alt_oe = 24'h00_00F0;
  logic [7:0] irq_vector;
  int error_cnt = 0;
  int samples_checked = 0;
  // port register bases
  localparam logic [11:0] PB = 12'h268;
  localparam logic [11:0] PC = 12'h278;
  localparam logic [11:0] PD = 12'h288;
  localparam logic [11:0] PWR = 12'h36C;

  // free-running clock
  always #5 clk = ~clk;

  gpp_top dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in),
    .irq_req(irq_req), .irq_any(irq_any), .irq_vector(irq_vector));
  gpp_pins_model pins_u (.clk(clk), .drv_out(pin_out), .drv_oe(pin_oe),
    .ext_en(ext_en), .ext_val(ext_val), .lvl(pin_in));

  // one apb transfer, answer kept in rdat and rerr
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // hold the request until ready; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // compare seen against expected
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // let edges pass, then look after the updates
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // write one byte register
  task automatic wr8(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d});
  endtask

  // set the three mode registers of a port
  task automatic cfg(input logic [11:0] b, input logic [7:0] a2, a1, dr);
    wr8(b + 12'h00C, a2);
    wr8(b + 12'h008, a1);
    wr8(b + 12'h004, dr);
    wt(3);
  endtask

  // verdict
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    end_sim;
  end

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wt(1);
    chk("oe", {8'h00, pin_oe}, 32'h0000_0000);
    chk("req", {8'h00, irq_req}, 32'h0000_0000);
    apb(1'b0, PB + 12'h004, 32'h0000_0000);
    chk("dir", rdat, 32'h0000_00FF);
    apb(1'b0, PB + 12'h008, 32'h0000_0000);
    chk("alt1", rdat, 32'h0000_0000);
    apb(1'b0, PWR, 32'h0000_0000);
    chk("pwr", rdat, 32'h0000_0000);
    // drivers of port b in every output style
    wr8(PB, 8'hA5);
    cfg(PB, 8'h00, 8'h00, 8'h00);
    chk("pp", {16'h0000, pin_oe[7:0], pin_out[7:0]}, 32'h0000_FFA5);
    apb(1'b0, PB, 32'h0000_0000);
    chk("rd", rdat, 32'h0000_00A5);
    cfg(PB, 8'h00, 8'hFF, 8'h00);
    chk("od", {pin_oe[7:0], pin_out[7:0] & pin_oe[7:0]}, 32'h5A00);
    cfg(PB, 8'h00, 8'hFF, 8'hFF);
    chk("os", {pin_oe[7:0], pin_out[7:0] & pin_oe[7:0]}, 32'hA5A5);
    cfg(PB, 8'h00, 8'h00, 8'hFF);
    chk("in", {24'h00_0000, pin_oe[7:0]}, 32'h0000_0000);
    cfg(PB, 8'hFF, 8'h00, 8'hFF);
    chk("alt", {pin_oe[7:0], pin_out[7:0]}, 32'hF03C);
    // dual edge on port c pin 0
    wr8(PC, 8'hFF);
    cfg(PC, 8'hFF, 8'h00, 8'h00);
    chk("c_oe", {24'h00_0000, pin_oe[15:8]}, 32'h0000_0000);
    @(posedge clk) ext_val[8] <= 1'b1;
    wt(3);
    chk("rise", {31'h0, irq_req[8]}, 32'h0000_0001);
    wt(1);
    chk("vec", {24'h00_0000, irq_vector}, 32'h0000_0040);
    @(posedge clk) ext_val[8] <= 1'b0;
    wr8(PC, 8'hFE);
    wt(2);
    chk("w0", {31'h0, irq_req[8]}, 32'h0000_0001);
    wr8(PC, 8'h01);
    wt(2);
    chk("clr", {31'h0, irq_req[8]}, 32'h0000_0000);
    // low level on port d pin 0
    wr8(PD, 8'h00);
    cfg(PD, 8'hFF, 8'hFF, 8'h00);
    @(posedge clk) ext_val[16] <= 1'b0;
    wt(2);
    chk("lv1", {31'h0, irq_req[16]}, 32'h0000_0000);
    wt(1);
    chk("lv2", {31'h0, irq_req[16]}, 32'h0000_0001);
    @(posedge clk) ext_val[16] <= 1'b1;
    wt(3);
    chk("lv3", {31'h0, irq_req[16]}, 32'h0000_0000);
    // rising edge only on port d pin 1
    wr8(PD, 8'hFF);
    cfg(PD, 8'hFF, 8'hFF, 8'hFF);
    @(posedge clk) ext_val[17] <= 1'b0;
    wt(3);
    chk("fall", {31'h0, irq_req[17]}, 32'h0000_0000);
    @(posedge clk) ext_val[17] <= 1'b1;
    wt(3);
    @(posedge clk) ext_val[17] <= 1'b0;
    wt(3);
    chk("hold", {31'h0, irq_req[17]}, 32'h0000_0001);
    wr8(PD, 8'h02);
    wt(2);
    chk("sclr", {31'h0, irq_req[17]}, 32'h0000_0000);
    // power down port b, unmapped place
    wr8(PWR, 8'h20);
    apb(1'b0, PWR, 32'h0000_0000);
    chk("pwr_rd", rdat, 32'h0000_0020);
    apb(1'b0, PB + 12'h004, 32'h0000_0000);
    chk("pd_b", {31'h0, rerr}, 32'h0000_0001);
    apb(1'b0, PC + 12'h004, 32'h0000_0000);
    chk("pd_c", {31'h0, rerr}, 32'h0000_0000);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("unmap", {31'h0, rerr}, 32'h0000_0001);
    wr8(PWR, 8'h00);
    end_sim;
  end
endmodule
